// ==== etu_top.sv ====
// event actions: trigger outputs, pattern port, event store, indicators, register slave
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module etu_top
  import etu_pkg::*;
#(
  parameter int PATW      = 16,
  parameter int CHANS     = 6,
  parameter int DW        = 32,
  parameter int MAW       = 16,
  parameter int BLINK     = BLINK_CYC,
  parameter int RUN_BLINK = RUN_BLINK_CYC
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic                       irq,
  // sequencer side
  input  wire logic                  seqEvent,
  input  wire logic [2:0]            seqState,
  input  wire logic                  seqLevelWe,
  input  wire logic                  seqLevelVal,
  input  wire logic [CHANS*DW-1:0]   chanValue,
  input  wire logic [DW-1:0]         timeValue,
  output logic                       syncEvent,
  output logic                       patMatch,
  // event store memory port
  output logic                       memWe,
  output logic      [MAW-1:0]        memAddr,
  output logic      [DW-1:0]         memData,
  // front panel pins
  input  wire logic                  ext_sync_input,
  output logic                       event_pulse_output,
  output logic                       event_level_output,
  input  wire logic [PATW-1:0]       patIn,
  output logic      [PATW-1:0]       patOut,
  output logic      [PATW-1:0]       patOe,
  // indicators
  output logic                       runLed,
  output logic                       syncInLed,
  output logic                       trigOutLed
);

  localparam int PCW = $clog2(PULSE_CYC + 1);
  localparam logic [PCW-1:0] PULSE_LOAD = PCW'(PULSE_CYC);
  localparam int RCW = $clog2(RUN_BLINK + 1);
  localparam logic [RCW-1:0] RUN_LAST = RCW'(RUN_BLINK - 1);
  localparam int CIW = $clog2(CHANS + 1);
  localparam logic [CIW-1:0] CHAN_LAST = CIW'(CHANS - 1);

  // ---------------- register slave ----------------
  logic [ACT_W-1:0] action;
  logic [PATW-1:0]  dirReg;
  logic [PATW-1:0]  patNext;
  logic [PATW-1:0]  latchEn;
  logic [PATW-1:0]  maskReg;
  logic [PATW-1:0]  matchReg;
  logic [PATW-1:0]  patSample;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  irqMask;
  logic [MAW-1:0]   storePtr;
  logic             wrPend;
  logic [7:0]       wrAddr;
  logic [PATW-1:0]  patNow;

  wire addrPhase = hsel & hready & htrans[1];
  wire rdAccept  = addrPhase & ~hwrite;
  wire wrAccept  = addrPhase & hwrite;
  wire upperZero = (haddr[31:8] == 24'h000000);
  wire [7:0] rdOfs = haddr[7:0];

  wire wrAction  = wrPend & (wrAddr == OFS_ACTION);
  wire wrLevel   = wrPend & (wrAddr == OFS_LEVEL);
  wire wrDir     = wrPend & (wrAddr == OFS_DIR);
  wire wrPatOut  = wrPend & (wrAddr == OFS_PATOUT);
  wire wrPatNext = wrPend & (wrAddr == OFS_PATNEXT);
  wire wrLatch   = wrPend & (wrAddr == OFS_LATCH);
  wire wrMask    = wrPend & (wrAddr == OFS_MASK);
  wire wrMatch   = wrPend & (wrAddr == OFS_MATCH);
  wire wrIrqMask = wrPend & (wrAddr == OFS_IRQMASK);
  wire wrStorePt = wrPend & (wrAddr == OFS_STOREPT);
  wire rdStatus  = rdAccept & upperZero & (rdOfs == OFS_STATUS);

  wire [31:0] rdMux =
      !upperZero                ? 32'h00000000 :
      (rdOfs == OFS_ACTION)     ? {{(32-ACT_W){1'b0}}, action} :
      (rdOfs == OFS_LEVEL)      ? {31'h00000000, event_level_output} :
      (rdOfs == OFS_DIR)        ? {{(32-PATW){1'b0}}, dirReg} :
      (rdOfs == OFS_PATOUT)     ? {{(32-PATW){1'b0}}, patOut} :
      (rdOfs == OFS_PATNEXT)    ? {{(32-PATW){1'b0}}, patNext} :
      (rdOfs == OFS_LATCH)      ? {{(32-PATW){1'b0}}, latchEn} :
      (rdOfs == OFS_MASK)       ? {{(32-PATW){1'b0}}, maskReg} :
      (rdOfs == OFS_MATCH)      ? {{(32-PATW){1'b0}}, matchReg} :
      (rdOfs == OFS_SAMPLE)     ? {{(32-PATW){1'b0}}, patSample} :
      (rdOfs == OFS_PATNOW)     ? {{(32-PATW){1'b0}}, patNow} :
      (rdOfs == OFS_STATUS)     ? {{(32-ST_W){1'b0}}, status} :
      (rdOfs == OFS_IRQMASK)    ? {{(32-ST_W){1'b0}}, irqMask} :
      (rdOfs == OFS_STOREPT)    ? {{(32-MAW){1'b0}}, storePtr} :
                                  32'h00000000;

  // zero wait states: read data is registered off the address phase
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend    <= wrAccept & upperZero;
      wrAddr    <= haddr[7:0];
      if (rdAccept) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      action   <= RST_ACTION;
      dirReg   <= RST_DIR;
      patNext  <= RST_PAT;
      latchEn  <= RST_PAT;
      maskReg  <= RST_PAT;
      matchReg <= RST_PAT;
      irqMask  <= RST_IRQMASK;
    end else begin
      if (wrAction)  action   <= hwdata[ACT_W-1:0];
      if (wrDir)     dirReg   <= hwdata[PATW-1:0];
      if (wrPatNext) patNext  <= hwdata[PATW-1:0];
      if (wrLatch)   latchEn  <= hwdata[PATW-1:0];
      if (wrMask)    maskReg  <= hwdata[PATW-1:0];
      if (wrMatch)   matchReg <= hwdata[PATW-1:0];
      if (wrIrqMask) irqMask  <= hwdata[ST_W-1:0];
    end
  end

  // ---------------- input synchronisers ----------------
  logic [2:0]      syncPipe;
  logic            syncLevel;
  logic [PATW-1:0] patS1;
  logic [PATW-1:0] patS2;
  logic [PATW-1:0] patS3;
  logic [PATW-1:0] patStable;
  logic [PATW-1:0] holdBits;

  wire             syncAgree = (syncPipe[1] == syncPipe[2]);
  wire             syncRise  = syncAgree & syncPipe[1] & ~syncLevel;
  wire [PATW-1:0]  patAgree  = ~(patS2 ^ patS3);
  wire [PATW-1:0]  next_patStable = (patAgree & patS2) | (~patAgree & patStable);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncPipe  <= 3'h0;
      syncLevel <= 1'b0;
      syncEvent <= 1'b0;
      patS1     <= RST_PAT;
      patS2     <= RST_PAT;
      patS3     <= RST_PAT;
      patStable <= RST_PAT;
    end else begin
      syncPipe  <= {syncPipe[1:0], ext_sync_input};
      if (syncAgree) syncLevel <= syncPipe[1];
      syncEvent <= syncRise;
      patS1     <= patIn;
      patS2     <= patS1;
      patS3     <= patS2;
      patStable <= next_patStable;
    end
  end

  // ---------------- event actions ----------------
  wire evPulse = seqEvent & action[ACT_PULSE];
  wire evLevel = seqEvent & action[ACT_LEVEL];
  wire evPat   = seqEvent & action[ACT_PATOUT];
  wire evStore = seqEvent & action[ACT_STORE];

  // held pulses survive until the event sample takes them; a pulse in that cycle is kept
  wire [PATW-1:0] patInputs = patStable & ~dirReg;
  wire [PATW-1:0] next_holdBits =
      (holdBits & ~{PATW{seqEvent}}) | (patInputs & latchEn);
  assign patNow = (dirReg & patOut) | (~dirReg & (patStable | (holdBits & latchEn)));

  wire matchNow = ((patNow & maskReg) == (matchReg & maskReg));

  logic [PCW-1:0] pulseCnt;
  logic           trigActivity;

  // software write wins over sequencer command, which wins over toggle
  wire next_level = wrLevel    ? hwdata[0] :
                    seqLevelWe ? seqLevelVal :
                    evLevel    ? ~event_level_output :
                                 event_level_output;

  // retrigger restarts the pulse, so a retriggered pulse stretches past the fixed length
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulseCnt           <= '0;
      event_pulse_output <= 1'b0;
      event_level_output <= 1'b0;
      trigActivity       <= 1'b0;
    end else begin
      if (evPulse) begin
        pulseCnt           <= PULSE_LOAD - PCW'(1);
        event_pulse_output <= 1'b1;
      end else if (pulseCnt != '0) begin
        pulseCnt <= pulseCnt - PCW'(1);
      end else begin
        event_pulse_output <= 1'b0;
      end
      event_level_output <= next_level;
      trigActivity       <= evPulse | (next_level != event_level_output);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      patOut    <= RST_PAT;
      patOe     <= RST_DIR;
      patSample <= RST_PAT;
      holdBits  <= RST_PAT;
      patMatch  <= 1'b0;
    end else begin
      if (wrPatOut)   patOut <= hwdata[PATW-1:0];
      else if (evPat) patOut <= patNext;
      patOe    <= dirReg;
      if (seqEvent) patSample <= patNow;
      holdBits <= next_holdBits;
      patMatch <= matchNow;
    end
  end

  // ---------------- event store ----------------
  etu_sto_e       stoState;
  etu_sto_e       next_stoState;
  logic [CIW-1:0] chanIdx;
  logic [DW-1:0]  chanHold [CHANS];
  logic [DW-1:0]  timeHold;
  logic [PATW-1:0] patHold;
  logic           storePat;

  wire stoBusy    = (stoState != STO_IDLE);
  wire stoStart   = evStore & ~stoBusy;
  wire stoOverrun = evStore & stoBusy;
  wire stoDone    = ((stoState == STO_TIME) & ~storePat) | (stoState == STO_PAT);

  always_comb begin
    next_stoState = stoState;
    unique case (stoState)
      STO_IDLE: if (stoStart) next_stoState = STO_CHAN;
      STO_CHAN: if (chanIdx == CHAN_LAST) next_stoState = STO_TIME;
      STO_TIME: next_stoState = storePat ? STO_PAT : STO_IDLE;
      STO_PAT:  next_stoState = STO_IDLE;
    endcase
  end

  wire [DW-1:0] stoWord =
      (stoState == STO_CHAN) ? chanHold[chanIdx] :
      (stoState == STO_TIME) ? timeHold :
                               {{(DW-PATW){1'b0}}, patHold};

  // values are frozen at the event so a slow store still records event-time data
  always_ff @(posedge mclk) begin
    if (stoStart) begin
      for (int i = 0; i < CHANS; i++) begin
        chanHold[i] <= chanValue[i*DW +: DW];
      end
      timeHold <= timeValue;
      patHold  <= patNow;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stoState <= STO_IDLE;
      chanIdx  <= '0;
      storePat <= 1'b0;
      storePtr <= '0;
      memWe    <= 1'b0;
      memAddr  <= '0;
      memData  <= '0;
    end else begin
      stoState <= next_stoState;
      memWe    <= stoBusy;
      memAddr  <= storePtr;
      memData  <= stoWord;
      if (stoStart) begin
        chanIdx  <= '0;
        storePat <= action[ACT_STPAT];
      end else if (stoState == STO_CHAN) begin
        chanIdx <= chanIdx + CIW'(1);
      end
      if (wrStorePt) storePtr <= hwdata[MAW-1:0];
      else if (stoBusy) storePtr <= storePtr + MAW'(1);
    end
  end

  // ---------------- status and interrupt ----------------
  logic matchPrev;
  wire [ST_W-1:0] stSet;
  assign stSet[ST_EVENT]   = seqEvent;
  assign stSet[ST_SYNCIN]  = syncRise;
  assign stSet[ST_MATCH]   = matchNow & ~matchPrev;
  assign stSet[ST_STDONE]  = stoDone;
  assign stSet[ST_OVERRUN] = stoOverrun;

  // read clears, but a same-cycle event still sets
  wire [ST_W-1:0] next_status = (status & ~{ST_W{rdStatus}}) | stSet;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status    <= '0;
      // a trivial match right after reset is not a rising edge
      matchPrev <= 1'b1;
      irq       <= 1'b0;
    end else begin
      status    <= next_status;
      matchPrev <= matchNow;
      irq       <= |(next_status & irqMask);
    end
  end

  // ---------------- indicators ----------------
  logic [RCW-1:0] runCnt;
  logic           runPhase;
  wire            seqRun   = (seqState == SEQ_RUN);
  wire            seqPause = (seqState == SEQ_STOP) | (seqState == SEQ_BREAK);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      runCnt   <= '0;
      runPhase <= 1'b0;
      runLed   <= 1'b0;
    end else begin
      if (runCnt == RUN_LAST) begin
        runCnt   <= '0;
        runPhase <= ~runPhase;
      end else begin
        runCnt <= runCnt + RCW'(1);
      end
      runLed <= seqRun | (seqPause & runPhase);
    end
  end

  etu_blink #(.HOLD(BLINK)) u_syncBlink (
    .mclk (mclk),
    .rst_n(rst_n),
    .trig (syncRise),
    .led  (syncInLed)
  );

  etu_blink #(.HOLD(BLINK)) u_trigBlink (
    .mclk (mclk),
    .rst_n(rst_n),
    .trig (trigActivity),
    .led  (trigOutLed)
  );

endmodule

// ==== etu_pkg.sv ====
// constants, register map and types of the event trigger output unit
package etu_pkg;

  // clock and timing
  localparam int CLK_MHZ        = 100;
  localparam int PULSE_NS       = 100;
  localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_MS       = 50;
  localparam int BLINK_CYC      = BLINK_MS * CLK_MHZ * 1000;
  localparam int RUN_BLINK_MS   = 250;
  localparam int RUN_BLINK_CYC  = RUN_BLINK_MS * CLK_MHZ * 1000;
  localparam int ACT_LATENCY    = 1;

  // register byte offsets
  localparam logic [7:0] OFS_ACTION  = 8'h00;
  localparam logic [7:0] OFS_LEVEL   = 8'h04;
  localparam logic [7:0] OFS_DIR     = 8'h08;
  localparam logic [7:0] OFS_PATOUT  = 8'h0C;
  localparam logic [7:0] OFS_PATNEXT = 8'h10;
  localparam logic [7:0] OFS_LATCH   = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_MATCH   = 8'h1C;
  localparam logic [7:0] OFS_SAMPLE  = 8'h20;
  localparam logic [7:0] OFS_PATNOW  = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;
  localparam logic [7:0] OFS_IRQMASK = 8'h2C;
  localparam logic [7:0] OFS_STOREPT = 8'h30;

  // action register fields
  localparam int ACT_PULSE  = 0;
  localparam int ACT_LEVEL  = 1;
  localparam int ACT_PATOUT = 2;
  localparam int ACT_STORE  = 3;
  localparam int ACT_STPAT  = 4;
  localparam int ACT_W      = 5;

  // status and mask fields
  localparam int ST_EVENT   = 0;
  localparam int ST_SYNCIN  = 1;
  localparam int ST_MATCH   = 2;
  localparam int ST_STDONE  = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_W       = 5;

  // reset values
  localparam logic [ACT_W-1:0] RST_ACTION  = 5'h00;
  localparam logic [15:0]      RST_DIR     = 16'hFF00;
  localparam logic [15:0]      RST_PAT     = 16'h0000;
  localparam logic [ST_W-1:0]  RST_IRQMASK = 5'h00;

  // sequencer program state, as reported by the sequencer
  typedef enum logic [2:0] {
    SEQ_IDLE        = 3'h0,
    SEQ_EMPTY_STORE = 3'h1,
    SEQ_CODE_LOADED = 3'h2,
    SEQ_RUN         = 3'h3,
    SEQ_STOP        = 3'h4,
    SEQ_BREAK       = 3'h5,
    SEQ_ERROR       = 3'h6
  } etu_seq_e;

  // store sequencer states, gray along channel -> time -> pattern
  typedef enum logic [1:0] {
    STO_IDLE = 2'b00,
    STO_CHAN = 2'b01,
    STO_TIME = 2'b11,
    STO_PAT  = 2'b10
  } etu_sto_e;

endpackage

// ==== etu_blink.sv ====
// retriggerable activity stretcher for indicator lamps
`timescale 1ns/1ps
module etu_blink #(
  parameter int HOLD = 1000
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // activity in, lamp out
  input  wire logic trig,
  output logic      led
);

  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] LOAD = CW'(HOLD - 1);

  logic [CW-1:0] cnt;
  wire           busy = (cnt != '0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt <= '0;
      led <= 1'b0;
    end else if (trig) begin
      cnt <= LOAD;
      led <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - CW'(1);
    end else begin
      led <= 1'b0;
    end
  end

endmodule

// ==== etu_ext_model.sv ====
// instrument model on the sync input and pattern lines
`timescale 1ns/1ps
module etu_ext_model (
  // requests from the bench
  input  wire logic        syncReq,
  input  wire logic [15:0] patReq,
  // pins of the unit
  input  wire logic [15:0] patOut,
  input  wire logic [15:0] patOe,
  output logic             ext_sync_input,
  output logic [15:0]      patIn
);
  assign ext_sync_input = syncReq;
  // unit owns enabled lines, instrument the rest
  assign patIn = (patOe & patOut) | (~patOe & patReq);
endmodule

// ==== etu_monitor.sv ====
// concurrent checks on the event unit ports
`timescale 1ns/1ps
module etu_monitor
  import etu_pkg::*;
(
  // clock, reset, sequencer
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        seqEvent,
  input wire logic [2:0]  seqState,
  input wire logic        seqLevelWe,
  input wire logic        seqLevelVal,
  // pins and status
  input wire logic        ext_sync_input,
  input wire logic        hresp,
  input wire logic        hreadyout,
  input wire logic        syncEvent,
  input wire logic        memWe,
  input wire logic        event_pulse_output,
  input wire logic        event_level_output,
  input wire logic [15:0] patOe,
  input wire logic        runLed,
  input wire logic        trigOutLed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [3:0] evAge;
  // saturates so a long quiet spell never wraps into the window
  always_ff @(posedge mclk) begin
    if (!rst_n) evAge <= 4'hF;
    else if (seqEvent) evAge <= 4'h1;
    else if (evAge != 4'hF) evAge <= evAge + 4'h1;
  end
  pulse_window_a: assert property (event_pulse_output |-> evAge inside {[4'h1:4'hA]})
    else $error("pulse outside event window");
  pulse_len_a: assert property ($fell(event_pulse_output) |-> $past(evAge) == 4'hA)
    else $error("pulse not ten cycles");
  pulse_cause_a: assert property ($rose(event_pulse_output) |-> $past(seqEvent))
    else $error("pulse without event");
  level_seq_a: assert property (seqLevelWe |=> event_level_output == $past(seqLevelVal))
    else $error("sequencer level not taken");
  run_on_a: assert property (seqState == SEQ_RUN |=> runLed)
    else $error("run lamp off while running");
  run_off_a: assert property (seqState inside {SEQ_IDLE, SEQ_EMPTY_STORE, SEQ_CODE_LOADED, SEQ_ERROR}
    |=> !runLed)
    else $error("run lamp on while not running");
  sync_lat_a: assert property ($rose(ext_sync_input) |-> ##[2:6] syncEvent)
    else $error("sync edge not seen");
  sync_one_a: assert property (syncEvent |=> !syncEvent)
    else $error("sync event too long");
  store_len_a: assert property ($rose(memWe) |-> memWe[*7] ##1 (!memWe or (memWe ##1 !memWe)))
    else $error("store burst length wrong");
  store_start_a: assert property ($rose(memWe) |-> $past(seqEvent, 2) || $past(seqEvent, 3))
    else $error("store without event");
  bus_okay_a: assert property ($past(rst_n) |-> hreadyout && !hresp)
    else $error("bus not ready or error");
  trig_led_a: assert property ($rose(event_pulse_output) |-> ##[0:2] trigOutLed)
    else $error("trigger lamp dark");
  dir_reset_a: assert property (!$past(rst_n) |-> patOe == RST_DIR)
    else $error("direction reset wrong");
  cover property ($rose(event_pulse_output));
  cover property ($rose(memWe));
  cover property (syncEvent);
  cover property (seqState == SEQ_BREAK && $rose(runLed));
endmodule
bind etu_top etu_monitor etu_monitor_inst (.mclk(mclk), .rst_n(rst_n), .seqEvent(seqEvent),
  .seqState(seqState), .seqLevelWe(seqLevelWe), .seqLevelVal(seqLevelVal),
  .ext_sync_input(ext_sync_input), .hresp(hresp), .hreadyout(hreadyout), .syncEvent(syncEvent),
  .memWe(memWe), .event_pulse_output(event_pulse_output), .event_level_output(event_level_output),
  .patOe(patOe), .runLed(runLed), .trigOutLed(trigOutLed));

// ==== tb.sv ====
// self-checking bench for the event trigger output unit
`timescale 1ns/1ps
module tb
  import etu_pkg::*;
;
  logic         mclk = 0, rst_n = 0, hwrite = 0, seqEvent = 0, seqLevelWe = 0;
  logic         seqLevelVal = 0, syncReq = 0;
  logic [31:0]  haddr = 0, hwdata = 0, hrdata, memData, fd, ft, fp;
  logic [1:0]   htrans = 0;
  logic [2:0]   seqState = 0;
  logic [191:0] chanValue;
  logic [15:0]  patReq = 0, patIn, patOut, patOe, memAddr, fa;
  logic         hreadyout, hresp, irq, syncEvent, patMatch, memWe, ext_sync_input;
  logic         event_pulse_output, event_level_output, runLed, syncInLed, trigOutLed;
  int           mismatches = 0, check_count = 0, words = 0;
  logic [4:0]   rowAct [4] = '{5'h00, 5'h01, 5'h02, 5'h03};
  logic [4:0]   rowLen [4] = '{5'h00, 5'h0A, 5'h00, 5'h0A};
  logic [3:0]   rowTog = 4'b1100;

  initial for (int i = 0; i < 6; i++) chanValue[i*32+:32] = 32'hCA000000 + i;
  always #5 mclk = ~mclk;
  // burst counter runs beside the main sequence so no word is missed
  always @(posedge mclk) begin
    if (memWe === 1'b1) begin
      if (words == 0) begin
        fa = memAddr;
        fd = memData;
      end
      if (words == 6) ft = memData;
      if (words == 7) fp = memData;
      words++;
    end
  end

  etu_top #(.BLINK(8), .RUN_BLINK(16)) etu_top_inst (
    .mclk(mclk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .seqEvent(seqEvent), .seqState(seqState), .seqLevelWe(seqLevelWe),
    .seqLevelVal(seqLevelVal), .chanValue(chanValue), .timeValue(32'h0000_7E11),
    .syncEvent(syncEvent), .patMatch(patMatch), .memWe(memWe), .memAddr(memAddr), .memData(memData),
    .ext_sync_input(ext_sync_input), .event_pulse_output(event_pulse_output),
    .event_level_output(event_level_output), .patIn(patIn), .patOut(patOut), .patOe(patOe),
    .runLed(runLed), .syncInLed(syncInLed), .trigOutLed(trigOutLed));
  etu_ext_model etu_ext_model_inst (.syncReq(syncReq), .patReq(patReq), .patOut(patOut),
    .patOe(patOe), .ext_sync_input(ext_sync_input), .patIn(patIn));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge mclk);
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    d = hrdata;
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask
  task automatic strobe(input logic ev, input logic we, input logic v);
    @(posedge mclk);
    seqEvent <= ev;
    seqLevelWe <= we;
    seqLevelVal <= v;
    @(posedge mclk);
    seqEvent <= 1'b0;
    seqLevelWe <= 1'b0;
    #1;
  endtask

  initial begin
    int n;
    logic [31:0] d;
    logic lv;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("patOe", 32'hFF00, patOe);
    chk("level0", 0, event_level_output);
    chk("pulse0", 0, event_pulse_output);
    bus(1'b0, OFS_DIR, 0, d);
    chk("dirReg", 32'hFF00, d);
    for (int r = 0; r < 4; r++) begin
      bw(OFS_ACTION, {27'h0, rowAct[r]});
      lv = event_level_output;
      strobe(1'b1, 1'b0, 1'b0);
      n = 0;
      while (event_pulse_output === 1'b1 && n < 20) begin
        n++;
        @(posedge mclk);
        #1;
      end
      chk("pulseLen", rowLen[r], n);
      chk("toggle", lv ^ rowTog[r], event_level_output);
    end
    strobe(1'b0, 1'b1, 1'b1);
    chk("seqLevel", 1, event_level_output);
    bw(OFS_LEVEL, 32'h0);
    #1;
    chk("swLevel", 0, event_level_output);
    @(posedge mclk);
    patReq <= 16'h005A;
    bw(OFS_PATOUT, 32'hA500);
    #1;
    chk("patOut", 32'hA500, patOut);
    bw(OFS_PATNEXT, 32'h3C00);
    bw(OFS_ACTION, 32'h04);
    strobe(1'b1, 1'b0, 1'b0);
    chk("patAuto", 32'h3C00, patOut);
    bus(1'b0, OFS_SAMPLE, 0, d);
    chk("sample", 32'h5A, d & 32'hFF);
    bw(OFS_MASK, 32'h00FF);
    bw(OFS_MATCH, 32'h005A);
    repeat (3) @(posedge mclk);
    #1;
    chk("match", 1, patMatch);
    bw(OFS_LATCH, 32'h0001);
    @(posedge mclk);
    patReq <= 16'h0051;
    // two cycles wide, so the three-stage filter lets it through
    repeat (2) @(posedge mclk);
    patReq <= 16'h0050;
    repeat (8) @(posedge mclk);
    #1;
    chk("noMatch", 0, patMatch);
    bus(1'b0, OFS_PATNOW, 0, d);
    chk("heldBit", 1, d[0]);
    bus(1'b0, OFS_STATUS, 0, d);
    bw(OFS_STOREPT, 32'h0040);
    bw(OFS_ACTION, 32'h18);
    words = 0;
    strobe(1'b1, 1'b0, 1'b0);
    // second event lands while the burst is still running
    strobe(1'b1, 1'b0, 1'b0);
    repeat (16) @(posedge mclk);
    #1;
    chk("words", 8, words);
    chk("firstAddr", 32'h40, fa);
    chk("firstData", chanValue[31:0], fd);
    chk("timeWord", 32'h00007E11, ft);
    chk("patWord", 32'h00003C51, fp);
    chk("irqMasked", 0, irq);
    bus(1'b0, OFS_STATUS, 0, d);
    chk("status", 32'h19, d & 32'h19);
    bw(OFS_IRQMASK, 32'h02);
    @(posedge mclk);
    syncReq <= 1'b1;
    n = 0;
    while (syncEvent !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("syncSeen", 1, syncEvent);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq", 1, irq);
    chk("syncLed", 1, syncInLed);
    bus(1'b0, OFS_STATUS, 0, d);
    chk("stSync", 32'h02, d & 32'h02);
    @(posedge mclk);
    #1;
    chk("irqClr", 0, irq);
    bus(1'b0, 8'h40, 0, d);
    chk("unmapped", 0, d);
    for (int s = 0; s < 7; s++) begin
      @(posedge mclk);
      seqState <= s[2:0];
      repeat (3) @(posedge mclk);
      #1;
      if (s != 4 && s != 5) chk("runLed", s == 3, runLed);
    end
    @(posedge mclk);
    seqState <= SEQ_BREAK;
    lv = runLed;
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (runLed !== lv) n++;
      lv = runLed;
    end
    chk("blink", 1, n >= 2);
    // reset in mid-run with the level output high and actions armed
    bw(OFS_LEVEL, 32'h1);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("levelRst", 0, event_level_output);
    chk("pulseRst", 0, event_pulse_output);
    chk("patOeRst", 32'hFF00, patOe);
    bus(1'b0, OFS_ACTION, 0, d);
    chk("actionRst", 0, d);
    final_report();
  end
endmodule
